// >>> hw/low_power_mode_controller.sv
/*
  Low power mode controller: Idle, Sleep, paging, Deep Sleep and AP search,
  host wake request and host alert handling, AHB-Lite register slave.
  Assumes activity inputs come from logic on clk_i; wake_request_n_i is a pin.
*/
// Design decisions made here: register access over AHB-Lite and the register offsets.
module low_power_mode_controller
  import lp_pkg::*;
#(
  parameter int unsigned CYC_MS = lp_pkg::CYC_PER_MS,
  parameter int unsigned CYC_S  = lp_pkg::CYC_PER_S
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Host pins
  input  wire logic        wake_request_n_i,
  output logic             host_alert_n_o,
  // Activity and events from the module's own logic
  input  wire logic        host_cmd_busy_i,
  input  wire logic        wpa_busy_i,
  input  wire logic        carrier_loss_i,
  input  wire logic        socket_pending_i,
  input  wire logic        sersock_pending_i,
  input  wire logic        serial_activity_i,
  input  wire logic        net_rx_i,
  input  wire logic        task_busy_i,
  input  wire logic        ext_irq_i,
  input  wire logic        net_data_ind_i,
  input  wire logic        ap_linked_i,
  input  wire logic        search_fail_i,
  // Power control outputs
  output logic             serial_en_o,
  output logic             stacked_bus_power_out_o,
  output logic             iface_hold_o,
  output logic             search_req_o,
  output logic             send_ok_o
);

  import lp_pkg::*;

  // Settings
  logic [7:0]  sleep_timeout_setting_r;
  logic        radio_power_save_setting_r;
  logic        serial_socket_mode_r;
  logic [15:0] host_alert_delay_ms_r;
  logic [15:0] host_alert_min_gap_ms_r;
  logic [15:0] ap_search_interval_setting_r;

  // Bus state
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] status_w;

  // Core state
  pstate_type  state_r;
  pstate_type  state_nxt;
  logic        wk_meta_r;
  logic        wk_sync_r;
  logic        busy;
  logic        sleep_ok;
  logic        state_chg;
  logic        sec_clr;
  logic        ms_tick;
  logic        sec_tick;
  logic [15:0] ms_cnt_r;
  logic [15:0] sec_cnt_r;
  logic        net_wake;
  logic        alert_en;
  logic        alert_pend_r;
  logic        alert_on;
  logic [15:0] gap_cnt_r;
  logic [15:0] alert_ms_r;
  logic        gap_ok;
  logic        lp_wake;

  // Wake request pin synchroniser; idle level is high
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wk_meta_r <= 1'b1;
      wk_sync_r <= 1'b1;
    end
    else
    begin
      wk_meta_r <= wake_request_n_i;
      wk_sync_r <= wk_meta_r;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wr_pend_r   <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
      wr_addr_r   <= haddr_i[7:0];
      if (hsel_i && htrans_i[1] && hready_i && !hwrite_i)
      begin
        if (haddr_i[31:8] != 24'h00_0000)
          hrdata_o <= 32'h0000_0000;
        else if (haddr_i[7:0] == OFS_CTRL)
          hrdata_o <= {22'h00_0000, serial_socket_mode_r, radio_power_save_setting_r,
                       sleep_timeout_setting_r};
        else if (haddr_i[7:0] == OFS_ALERT)
          hrdata_o <= {host_alert_min_gap_ms_r, host_alert_delay_ms_r};
        else if (haddr_i[7:0] == OFS_SEARCH)
          hrdata_o <= {16'h0000, ap_search_interval_setting_r};
        else if (haddr_i[7:0] == OFS_STATUS)
          hrdata_o <= status_w;
        else
          hrdata_o <= 32'h0000_0000;
      end
    end
  end

  assign status_w = {21'h00_0000, send_ok_o, serial_en_o, ~host_alert_n_o, 3'h0, state_r};

  // Settings written in the data phase
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sleep_timeout_setting_r      <= TMO_RST;
      radio_power_save_setting_r   <= RPS_RST;
      serial_socket_mode_r         <= SOCK_RST;
      host_alert_delay_ms_r        <= DLY_RST;
      host_alert_min_gap_ms_r      <= GAP_RST;
      ap_search_interval_setting_r <= SEARCH_RST;
    end
    else if (wr_pend_r)
    begin
      if (wr_addr_r == OFS_CTRL)
      begin
        sleep_timeout_setting_r    <= hwdata_i[CTRL_TMO_LSB +: 8];
        radio_power_save_setting_r <= hwdata_i[CTRL_RPS_BIT];
        serial_socket_mode_r       <= hwdata_i[CTRL_SOCK_BIT];
      end
      else if (wr_addr_r == OFS_ALERT)
      begin
        host_alert_delay_ms_r   <= hwdata_i[ALERT_DLY_LSB +: 16];
        host_alert_min_gap_ms_r <= hwdata_i[ALERT_GAP_LSB +: 16];
      end
      else if (wr_addr_r == OFS_SEARCH)
        ap_search_interval_setting_r <= hwdata_i[15:0];
    end
  end

  // Entry conditions
  assign busy = host_cmd_busy_i | wpa_busy_i | carrier_loss_i | socket_pending_i |
                sersock_pending_i | serial_activity_i | net_rx_i | task_busy_i;
  assign sleep_ok = wk_sync_r && (sleep_timeout_setting_r != 8'h00) &&
                    (host_alert_delay_ms_r != 16'h0000) && radio_power_save_setting_r &&
                    !busy;
  assign lp_wake = (sleep_timeout_setting_r == 8'h00) || !wk_sync_r || ext_irq_i ||
                   net_data_ind_i;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (!ap_linked_i && search_fail_i)
          state_nxt = ST_DEEP;
        else if (sleep_ok && sec_cnt_r >= {8'h00, sleep_timeout_setting_r})
          state_nxt = ST_SLEEP;
      ST_SLEEP:
        if (lp_wake)
          state_nxt = ST_IDLE;
        else if (ms_cnt_r >= PAGE_PERIOD_MS)
          state_nxt = ST_PAGE;
      ST_PAGE:
        if (lp_wake || serial_activity_i)
          state_nxt = ST_IDLE;
        else if (ms_cnt_r >= PAGE_WINDOW_MS)
          state_nxt = sleep_ok ? ST_SLEEP : ST_IDLE;
      ST_DEEP:
        if (!wk_sync_r || ext_irq_i)
          state_nxt = ST_IDLE;
        else if (sec_cnt_r >= ap_search_interval_setting_r)
          state_nxt = ST_SEARCH;
      ST_SEARCH:
        if (ap_linked_i)
          state_nxt = ST_IDLE;
        else if (search_fail_i)
          state_nxt = ST_DEEP;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Timers restart on every state change; the Idle seconds restart on activity
  assign state_chg = (state_nxt != state_r);
  assign sec_clr   = state_chg || (state_r == ST_IDLE && !sleep_ok);

  tick_gen #(
    .PERIOD (CYC_MS)
  ) u_ms_tick (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .clr_i    (state_chg),
    .tick_o   (ms_tick)
  );

  tick_gen #(
    .PERIOD (CYC_S)
  ) u_sec_tick (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .clr_i    (sec_clr),
    .tick_o   (sec_tick)
  );

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ms_cnt_r  <= 16'h0000;
      sec_cnt_r <= 16'h0000;
    end
    else
    begin
      if (state_chg)
        ms_cnt_r <= 16'h0000;
      else if (ms_tick && ms_cnt_r != 16'hFFFF)
        ms_cnt_r <= ms_cnt_r + 16'h0001;
      if (sec_clr)
        sec_cnt_r <= 16'h0000;
      else if (sec_tick && sec_cnt_r != 16'hFFFF)
        sec_cnt_r <= sec_cnt_r + 16'h0001;
    end
  end

  // Host alert
  assign alert_en = (host_alert_delay_ms_r != 16'h0000);
  assign alert_on = !host_alert_n_o;
  assign net_wake = (state_r == ST_SLEEP || state_r == ST_PAGE) && net_data_ind_i;
  assign gap_ok   = (gap_cnt_r >= host_alert_min_gap_ms_r);

  // The request set wins over the clear so a back-to-back indication is kept
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      alert_pend_r <= 1'b0;
    else if (net_wake && alert_en)
      alert_pend_r <= 1'b1;
    else if (!alert_en || (gap_ok && alert_on) || state_nxt == ST_SLEEP)
      alert_pend_r <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      host_alert_n_o <= 1'b1;
    else if (!alert_en)
      host_alert_n_o <= 1'b1;
    else if (alert_pend_r && gap_ok && wk_sync_r && !alert_on)
      host_alert_n_o <= 1'b0;
    else if (!wk_sync_r || state_nxt == ST_SLEEP)
      host_alert_n_o <= 1'b1;
  end

  // Gap resets to saturated so the first alert after reset is not held off
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gap_cnt_r  <= 16'hFFFF;
      alert_ms_r <= 16'h0000;
    end
    else if (alert_on)
    begin
      gap_cnt_r <= 16'h0000;
      if (ms_tick && alert_ms_r != 16'hFFFF)
        alert_ms_r <= alert_ms_r + 16'h0001;
    end
    else
    begin
      alert_ms_r <= 16'h0000;
      if (ms_tick && gap_cnt_r != 16'hFFFF)
        gap_cnt_r <= gap_cnt_r + 16'h0001;
    end
  end

  // Power control outputs follow the next state so they change with state_r
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      serial_en_o             <= 1'b1;
      stacked_bus_power_out_o <= 1'b1;
      iface_hold_o            <= 1'b0;
      search_req_o            <= 1'b0;
    end
    else
    begin
      serial_en_o  <= (state_nxt == ST_IDLE) || (state_nxt == ST_PAGE) ||
                      (state_nxt == ST_SEARCH);
      stacked_bus_power_out_o <= (state_nxt == ST_IDLE) || (state_nxt == ST_SEARCH);
      iface_hold_o <= (state_nxt == ST_SLEEP) || (state_nxt == ST_DEEP);
      search_req_o <= (state_nxt == ST_SEARCH);
    end
  end

  // In socket mode data to the host waits out the alert delay
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      send_ok_o <= 1'b1;
    else
      send_ok_o <= (state_r == ST_IDLE || state_r == ST_PAGE) &&
                   !(serial_socket_mode_r && alert_pend_r) &&
                   !(serial_socket_mode_r && alert_on &&
                     alert_ms_r < host_alert_delay_ms_r);
  end

  // Checks
  a_never_sleep_busy: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == ST_IDLE && busy) |=> state_r != ST_SLEEP)
    else $error("sleep entered while busy");

  a_entry_needs_ok: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == ST_IDLE ##1 state_r == ST_SLEEP) |-> $past(sleep_ok))
    else $error("sleep entered without entry conditions");

  a_zero_tmo_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == ST_SLEEP && sleep_timeout_setting_r == 8'h00) |=> state_r == ST_IDLE)
    else $error("zero timeout did not cancel sleep");

  a_wake_req_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == ST_SLEEP && !wk_sync_r) |=> (state_r == ST_IDLE && !iface_hold_o))
    else $error("wake request did not bring Idle");

  a_irq_wakes: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == ST_SLEEP && ext_irq_i) |=> state_r == ST_IDLE)
    else $error("interrupt ignored in sleep");

  a_sleep_outputs: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == ST_SLEEP) |-> (!serial_en_o && !stacked_bus_power_out_o && iface_hold_o))
    else $error("interfaces live during sleep");

  a_page_serial: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == ST_PAGE) |-> (serial_en_o && !iface_hold_o))
    else $error("serial off during paging");

  a_alert_disabled: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (host_alert_delay_ms_r == 16'h0000) |=> host_alert_n_o)
    else $error("alert driven with zero delay");

  a_alert_gap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(host_alert_n_o) |-> ($past(gap_cnt_r) >= $past(host_alert_min_gap_ms_r)
                               && $past(alert_pend_r)))
    else $error("alert reasserted inside gap");

  a_send_waits: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (serial_socket_mode_r && alert_on && alert_ms_r < host_alert_delay_ms_r) |=> !send_ok_o)
    else $error("data allowed before alert delay");

endmodule

// >>> hw/lp_pkg.sv
/*
  Shared constants for the low power mode controller: register offsets,
  field positions, reset values, timing figures and the power state type.
  Assumes a 125 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package lp_pkg;

  // Clock and time units
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam int unsigned CYC_PER_S     = CLK_HZ;

  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_ALERT     = 8'h04;
  localparam logic [7:0]  OFS_SEARCH    = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0C;

  // Field positions
  localparam int unsigned CTRL_TMO_LSB  = 0;
  localparam int unsigned CTRL_RPS_BIT  = 8;
  localparam int unsigned CTRL_SOCK_BIT = 9;
  localparam int unsigned ALERT_DLY_LSB = 0;
  localparam int unsigned ALERT_GAP_LSB = 16;
  localparam int unsigned STAT_ALERT_BIT = 8;
  localparam int unsigned STAT_SER_BIT  = 9;
  localparam int unsigned STAT_SEND_BIT = 10;

  // Reset values
  localparam logic [7:0]  TMO_RST       = 8'h00;
  localparam logic        RPS_RST       = 1'b1;
  localparam logic        SOCK_RST      = 1'b0;
  localparam logic [15:0] DLY_RST       = 16'h0000;
  localparam logic [15:0] GAP_RST       = 16'h0000;
  localparam logic [15:0] SEARCH_RST    = 16'h000A;

  // Paging figures in milliseconds
  localparam logic [15:0] PAGE_PERIOD_MS = 16'h03E8;
  localparam logic [15:0] PAGE_WINDOW_MS = 16'h000A;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_SLEEP  = 5'h02,
    ST_PAGE   = 5'h04,
    ST_DEEP   = 5'h08,
    ST_SEARCH = 5'h10
  } pstate_type;

endpackage

// >>> hw/tick_gen.sv
/*
  Periodic one-cycle tick generator with synchronous restart.
  Assumes clr_i comes from logic on the same clock.
*/
module tick_gen #(
  parameter int unsigned PERIOD = 125000
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Control
  input  wire logic clr_i,
  output logic      tick_o
);

  localparam int unsigned W = $clog2(PERIOD + 1);

  logic [W-1:0] cnt_r;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end
    else if (clr_i)
    begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end
    else if (cnt_r == W'(PERIOD - 1))
    begin
      cnt_r  <= '0;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule

// >>> tb/host_model.sv
/*
  Host application model on the far side of the host pins.
  Assumes clk_i is the device clock and the bench steers it through
  wake_hold_i (hold the device awake) and answer_i (reply to alerts).
*/
module host_model #(
  parameter int unsigned REPLY_CYC = 40
) (
  // Clock
  input  wire logic clk_i,
  // Bench controls
  input  wire logic wake_hold_i,
  input  wire logic answer_i,
  // Device pins
  input  wire logic host_alert_n_i,
  output logic      wake_request_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // The pin is only driven from the clocked process; reset spans the first edges
  int unsigned wait_cnt = 0;

  // Host needs some time to come up before it answers an alert
  always @(posedge clk_i)
  begin
    if (!answer_i || host_alert_n_i)
      wait_cnt <= 0;
    else if (wait_cnt < REPLY_CYC)
      wait_cnt <= wait_cnt + 1;
  end

  // Pin rests high; low while the host wants the device awake
  // No serial data is sent from here, so no settling wait is needed
  always @(posedge clk_i)
  begin
    wake_request_n_o <= !(wake_hold_i || (wait_cnt == REPLY_CYC && !host_alert_n_i));
  end
endmodule

// >>> tb/low_power_mode_controller_tb.sv
/*
  Testbench for the low power mode controller: AHB-Lite register tasks,
  a host model on the wake pins, and timed checks of every power state.
  Assumes shortened time units: CYC_MS = 4 and CYC_S = 16.
*/
module low_power_mode_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lp_pkg::*;

  localparam int MS = 4;
  localparam int S  = 16;

  logic        clk_i, arst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0]  htrans_i;
  logic        host_cmd_busy_i, wpa_busy_i, carrier_loss_i, socket_pending_i;
  logic        sersock_pending_i, serial_activity_i, net_rx_i, task_busy_i;
  logic        ext_irq_i, net_data_ind_i, ap_linked_i, search_fail_i;
  logic        wake_request_n_i, host_alert_n_o, serial_en_o, stacked_bus_power_out_o;
  logic        iface_hold_o, search_req_o, send_ok_o, wake_hold;
  logic [7:0]  busy;
  int          mismatches, num_checks, n;

  assign {task_busy_i, net_rx_i, serial_activity_i, sersock_pending_i,
          socket_pending_i, carrier_loss_i, wpa_busy_i, host_cmd_busy_i} = busy;

  low_power_mode_controller #(
    .CYC_MS (MS),
    .CYC_S  (S)
  ) u_dut (
    .clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i (3'b010),
    .hwdata_i,
    .hready_i (hreadyout_o),
    .hrdata_o, .hreadyout_o, .hresp_o, .wake_request_n_i, .host_alert_n_o,
    .host_cmd_busy_i, .wpa_busy_i, .carrier_loss_i, .socket_pending_i,
    .sersock_pending_i, .serial_activity_i, .net_rx_i, .task_busy_i,
    .ext_irq_i, .net_data_ind_i, .ap_linked_i, .search_fail_i,
    .serial_en_o, .stacked_bus_power_out_o, .iface_hold_o, .search_req_o, .send_ok_o
  );

  host_model #(
    .REPLY_CYC (40)
  ) u_host (
    .clk_i            (clk_i),
    .wake_hold_i      (wake_hold),
    .answer_i         (1'b1),
    .host_alert_n_i   (host_alert_n_o),
    .wake_request_n_o (wake_request_n_i)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic results();
    $display("Checks made %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic rng(input int cnt, input int lo, input int hi);
    chk({31'h0, cnt >= lo && cnt <= hi}, 32'h1);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // Called just after a rising edge; zero-wait slave still gets waited on
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel_i   <= 1'b1;
    haddr_i  <= {24'h000000, a};
    htrans_i <= 2'b10;
    hwrite_i <= wr;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    hsel_i   <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    rd = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic stc(input logic [4:0] e);
    logic [31:0] r;
    ahb(1'b0, OFS_STATUS, 32'h0, r);
    chk({27'h0, r[4:0]}, {27'h0, e});
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return iface_hold_o;
      1: return serial_en_o;
      2: return host_alert_n_o;
      3: return send_ok_o;
      default: return search_req_o;
    endcase
  endfunction

  // Counts falling edges until the output settles at lvl, then realigns
  task automatic waitfor(input int sel, input logic lvl, input int maxc, output int cnt);
    cnt = 0;
    while (pick(sel) !== lvl && cnt < maxc)
    begin
      @(negedge clk_i);
      cnt++;
    end
    @(posedge clk_i);
  endtask

  task automatic pulse_ndi();
    net_data_ind_i <= 1'b1;
    cyc(1);
    net_data_ind_i <= 1'b0;
  endtask

  initial
  begin
    cyc(30000);
    mismatches++;
    results();
  end

  initial
  begin
    {arst_n_i, hsel_i, hwrite_i, haddr_i, hwdata_i, htrans_i} = '0;
    {busy, ext_irq_i, net_data_ind_i, search_fail_i, wake_hold} = '0;
    ap_linked_i = 1'b1;
    mismatches = 0;
    num_checks = 0;
    cyc(8);
    arst_n_i <= 1'b1;
    cyc(1);
    chk({28'h0, host_alert_n_o, serial_en_o, stacked_bus_power_out_o, iface_hold_o},
        32'hE);
    chk({30'h0, hreadyout_o, hresp_o}, 32'h2);
    rdc(OFS_CTRL, 32'h0000_0100);
    rdc(OFS_ALERT, 32'h0000_0000);
    rdc(OFS_SEARCH, 32'h0000_000A);
    rdc(8'h10, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_0000);
    rdc(OFS_STATUS, 32'h0000_0601);
    cyc(100);
    stc(ST_IDLE);
    $display("Test reset done");

    wr(OFS_CTRL, 32'h0000_0102);
    cyc(80);
    stc(ST_IDLE);
    wr(OFS_ALERT, 32'h0100_0003);
    wr(OFS_CTRL, 32'h0000_0002);
    cyc(80);
    stc(ST_IDLE);
    wr(OFS_CTRL, 32'h0000_0102);
    for (int i = 0; i < 8; i++)
    begin
      busy <= 8'(1 << i);
      cyc(60);
      stc(ST_IDLE);
    end
    busy <= 8'h00;
    waitfor(0, 1'b1, 100, n);
    rng(n, 2 * S, 2 * S + 6);
    chk({28'h0, host_alert_n_o, serial_en_o, stacked_bus_power_out_o, iface_hold_o},
        32'h9);
    stc(ST_SLEEP);
    $display("Test sleep entry done");

    wake_hold <= 1'b1;
    waitfor(0, 1'b0, 8, n);
    rng(n, 1, 6);
    cyc(100);
    stc(ST_IDLE);
    wake_hold <= 1'b0;
    waitfor(0, 1'b1, 100, n);
    rng(n, 2 * S, 2 * S + 8);
    ext_irq_i <= 1'b1;
    cyc(1);
    ext_irq_i <= 1'b0;
    waitfor(0, 1'b0, 4, n);
    rng(n, 0, 2);
    waitfor(0, 1'b1, 100, n);
    rng(n, 2 * S - 4, 2 * S + 6);
    $display("Test wake sources done");

    wr(OFS_CTRL, 32'h0000_0302);
    pulse_ndi();
    busy <= 8'h80;
    waitfor(2, 1'b0, 6, n);
    rng(n, 1, 3);
    chk({31'h0, send_ok_o}, 32'h0);
    waitfor(3, 1'b1, 30, n);
    rng(n, 3 * MS - 2, 3 * MS + 4);
    waitfor(2, 1'b1, 60, n);
    rng(n, 20, 45);
    busy <= 8'h00;
    waitfor(0, 1'b1, 100, n);
    pulse_ndi();
    busy <= 8'h80;
    cyc(400);
    chk({31'h0, host_alert_n_o}, 32'h1);
    waitfor(2, 1'b0, 1200, n);
    rng(n, 450, 700);
    waitfor(2, 1'b1, 60, n);
    busy <= 8'h00;
    waitfor(0, 1'b1, 100, n);
    wr(OFS_ALERT, 32'h0000_0000);
    pulse_ndi();
    cyc(40);
    chk({31'h0, host_alert_n_o}, 32'h1);
    stc(ST_IDLE);
    wr(OFS_ALERT, 32'h0000_0003);
    waitfor(0, 1'b1, 100, n);
    $display("Test host alert done");

    waitfor(1, 1'b1, 4100, n);
    stc(ST_PAGE);
    chk({30'h0, stacked_bus_power_out_o, iface_hold_o}, 32'h0);
    waitfor(0, 1'b1, 60, n);
    rng(n, 10 * MS - 6, 10 * MS + 3);
    waitfor(1, 1'b1, 4100, n);
    rng(n, 1000 * MS - 4, 1000 * MS + 8);
    busy <= 8'h20;
    cyc(60);
    stc(ST_IDLE);
    busy <= 8'h00;
    waitfor(0, 1'b1, 100, n);
    rng(n, 2 * S, 2 * S + 8);
    wr(OFS_CTRL, 32'h0000_0100);
    waitfor(0, 1'b0, 4, n);
    rng(n, 0, 2);
    cyc(100);
    stc(ST_IDLE);
    $display("Test paging and cancel done");

    wr(OFS_SEARCH, 32'h0000_0002);
    ap_linked_i <= 1'b0;
    search_fail_i <= 1'b1;
    cyc(1);
    search_fail_i <= 1'b0;
    waitfor(0, 1'b1, 4, n);
    rng(n, 0, 2);
    stc(ST_DEEP);
    waitfor(4, 1'b1, 60, n);
    rng(n, 2 * S - 8, 2 * S + 4);
    chk({30'h0, serial_en_o, iface_hold_o}, 32'h2);
    search_fail_i <= 1'b1;
    cyc(1);
    search_fail_i <= 1'b0;
    waitfor(0, 1'b1, 4, n);
    rng(n, 0, 2);
    waitfor(4, 1'b1, 60, n);
    rng(n, 2 * S - 2, 2 * S + 4);
    ap_linked_i <= 1'b1;
    waitfor(4, 1'b0, 4, n);
    rng(n, 0, 3);
    stc(ST_IDLE);
    $display("Test deep sleep done");
    results();
  end
endmodule
